// ==== rtccal_pkg.sv ====
/*
 * Package for the calendar date registers of the real-time clock:
 * register offsets, field positions, reset values, bus responses and
 * the packed state of the top module.
 * Assumes an AXI4-Lite master with 32-bit data and 12-bit addresses.
 */
package rtccal_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // Register byte offsets, one aligned word each
  localparam logic [11:0] OFF_DAY = 12'h000;
  localparam logic [11:0] OFF_MONTH = 12'h004;
  localparam logic [11:0] OFF_YEAR = 12'h008;
  localparam logic [11:0] OFF_PAGE = 12'h00C;

  // Field widths and positions
  localparam int unsigned DAY_W = 6;
  localparam int unsigned MONTH_W = 5;
  localparam int unsigned YEAR_W = 8;
  localparam int unsigned LEAP_W = 2;
  localparam int unsigned FMT_BIT = 0;
  localparam int unsigned PAGE_BIT = 0;

  // BCD limits of the calendar
  localparam logic [7:0] BCD_ONE = 8'h01;
  localparam logic [7:0] BCD_ZERO = 8'h00;
  localparam logic [7:0] DAY_28 = 8'h28;
  localparam logic [7:0] DAY_29 = 8'h29;
  localparam logic [7:0] DAY_30 = 8'h30;
  localparam logic [7:0] DAY_31 = 8'h31;
  localparam logic [7:0] MON_FEB = 8'h02;
  localparam logic [7:0] MON_APR = 8'h04;
  localparam logic [7:0] MON_JUN = 8'h06;
  localparam logic [7:0] MON_SEP = 8'h09;
  localparam logic [7:0] MON_NOV = 8'h11;
  localparam logic [7:0] MON_DEC = 8'h12;
  localparam logic [7:0] YEAR_LAST = 8'h99;
  localparam logic [1:0] LEAP_YEAR = 2'h0;

  // Reset values (field contents are otherwise undefined)
  localparam logic [5:0] DAY_RST = 6'h01;
  localparam logic [4:0] MONTH_RST = 5'h01;
  localparam logic [7:0] YEAR_RST = 8'h00;
  localparam logic [1:0] LEAP_RST = 2'h0;
  localparam logic FMT_RST = 1'b0;
  localparam logic PAGE_RST = 1'b0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic aw_have;
    logic [11:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic page;
    logic [5:0] day;
    logic [4:0] month;
    logic fmt;
    logic [7:0] year;
    logic [1:0] leap;
  } rtccal_state_t;

  localparam rtccal_state_t ST_RESET = '{
    aw_have: 1'b0, aw_addr: 12'h000, w_have: 1'b0, w_data: 32'h00000000,
    w_strb: 4'h0, awready: 1'b1, wready: 1'b1, bvalid: 1'b0, bresp: 2'h0,
    arready: 1'b1, rvalid: 1'b0, rresp: 2'h0, rdata: 32'h00000000,
    page: PAGE_RST, day: DAY_RST, month: MONTH_RST, fmt: FMT_RST,
    year: YEAR_RST, leap: LEAP_RST};

endpackage : rtccal_pkg

// ==== rtccal_bcd_inc.sv ====
/*
 * Two-digit BCD step: returns the value plus one, or the first value
 * once the last value has been reached, with a wrap flag.
 * Assumes valid BCD codes at its input.
 */
`timescale 1ns/1ps
module rtccal_bcd_inc (
  input wire logic [7:0] value,
  input wire logic [7:0] first,
  input wire logic [7:0] last,
  output logic [7:0] next,
  output logic wrap
);

  always_comb begin
    wrap = (value == last);
    if (wrap) begin
      next = first;
    end else if (value[3:0] == 4'h9) begin
      next = {4'(value[7:4] + 4'h1), 4'h0};
    end else begin
      next = {value[7:4], 4'(value[3:0] + 4'h1)};
    end
  end

endmodule : rtccal_bcd_inc

// ==== rtccal_top.sv ====
/*
 * Calendar date registers of the real-time clock: day of month, month,
 * year, leap phase and the 12/24-hour select, behind an AXI4-Lite slave.
 * Assumes a single 40 MHz clock, a one-cycle day carry from the hour
 * counter, and software that follows the calendar coding conventions.
 */
// Behaviour
// - The day register holds a BCD day 01 to 31 in bits 5-0 and bits 7-6 read zero.
// - The day register is reached at its offset on either page.
// - The month register holds a BCD month 01 to 12 in bits 4-0 and bits 7-5 read zero.
// - The month location shows the month on page zero and the hour-format bit on page one.
// - On page one bit 0 of the month location selects 12-hour (0) or 24-hour (1), bits 7-1 read zero.
// - The year register on page zero holds a two-digit BCD year 00 to 99 in bits 7-0.
// - On page one the year location shows the leap phase and bits 7-2 read zero.
// - The leap phase in bits 1-0 gives the position in the four-year cycle, 00 being a leap year.
`timescale 1ns/1ps
module rtccal_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic day_carry,
  output logic hour_format_24,
  output logic page_one
);

  rtccal_pkg::rtccal_state_t st_reg;
  rtccal_pkg::rtccal_state_t st_next;

  // Calendar step chain: entry 0 day, 1 month, 2 year
  logic [7:0] cal_cur [3];
  logic [7:0] cal_first [3];
  logic [7:0] cal_last [3];
  logic [7:0] cal_step [3];
  logic cal_wrap [3];
  logic [7:0] month_end;

  always_comb begin
    unique case ({3'h0, st_reg.month})
      rtccal_pkg::MON_FEB: begin
        month_end = (st_reg.leap == rtccal_pkg::LEAP_YEAR) ? rtccal_pkg::DAY_29 : rtccal_pkg::DAY_28;
      end
      rtccal_pkg::MON_APR, rtccal_pkg::MON_JUN, rtccal_pkg::MON_SEP, rtccal_pkg::MON_NOV: begin
        month_end = rtccal_pkg::DAY_30;
      end
      default: begin
        month_end = rtccal_pkg::DAY_31;
      end
    endcase
  end

  assign cal_cur[0] = {2'h0, st_reg.day};
  assign cal_cur[1] = {3'h0, st_reg.month};
  assign cal_cur[2] = st_reg.year;
  assign cal_first[0] = rtccal_pkg::BCD_ONE;
  assign cal_first[1] = rtccal_pkg::BCD_ONE;
  assign cal_first[2] = rtccal_pkg::BCD_ZERO;
  assign cal_last[0] = month_end;
  assign cal_last[1] = rtccal_pkg::MON_DEC;
  assign cal_last[2] = rtccal_pkg::YEAR_LAST;

  for (genvar i = 0; i < 3; i++) begin : g_step
    rtccal_bcd_inc u_inc (
      .value(cal_cur[i]),
      .first(cal_first[i]),
      .last(cal_last[i]),
      .next(cal_step[i]),
      .wrap(cal_wrap[i])
    );
  end

  logic aw_take;
  logic w_take;
  logic ar_take;
  logic wr_go;
  logic wr_lane0;
  logic [7:0] wbyte;
  logic [11:0] ar_word;
  logic [11:0] aw_word;

  assign aw_take = s_axi_awvalid && st_reg.awready;
  assign w_take = s_axi_wvalid && st_reg.wready;
  assign ar_take = s_axi_arvalid && st_reg.arready;
  assign ar_word = {s_axi_araddr[11:2], 2'b00};

  always_comb begin
    st_next = st_reg;
    wr_go = 1'b0;
    wr_lane0 = 1'b0;
    wbyte = 8'h00;
    aw_word = 12'h000;

    // Date advance on the carry from the hour counter
    if (day_carry) begin
      st_next.day = cal_step[0][5:0];
      if (cal_wrap[0]) begin
        st_next.month = cal_step[1][4:0];
        if (cal_wrap[1]) begin
          st_next.year = cal_step[2];
          st_next.leap = 2'(st_reg.leap + 2'h1);
        end
      end
    end

    // Write address and data are caught in either order
    if (aw_take) begin
      st_next.aw_have = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
      st_next.awready = 1'b0;
    end
    if (w_take) begin
      st_next.w_have = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
      st_next.wready = 1'b0;
    end

    if (st_reg.aw_have && st_reg.w_have && !st_reg.bvalid) begin
      wr_go = 1'b1;
      wr_lane0 = st_reg.w_strb[0];
      wbyte = st_reg.w_data[7:0];
      aw_word = {st_reg.aw_addr[11:2], 2'b00};
      st_next.aw_have = 1'b0;
      st_next.w_have = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = rtccal_pkg::RESP_OKAY;
      // A software write overrides a carry in the same cycle
      unique case (aw_word)
        rtccal_pkg::OFF_DAY: begin
          if (wr_lane0) st_next.day = wbyte[5:0];
        end
        rtccal_pkg::OFF_MONTH: begin
          if (wr_lane0 && st_reg.page) st_next.fmt = wbyte[rtccal_pkg::FMT_BIT];
          if (wr_lane0 && !st_reg.page) st_next.month = wbyte[4:0];
        end
        rtccal_pkg::OFF_YEAR: begin
          if (wr_lane0 && st_reg.page) st_next.leap = wbyte[1:0];
          if (wr_lane0 && !st_reg.page) st_next.year = wbyte;
        end
        rtccal_pkg::OFF_PAGE: begin
          if (wr_lane0) st_next.page = wbyte[rtccal_pkg::PAGE_BIT];
        end
        default: begin
          st_next.bresp = rtccal_pkg::RESP_SLVERR;
        end
      endcase
    end

    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
      st_next.awready = 1'b1;
      st_next.wready = 1'b1;
    end

    // Read path: one read in flight, data held until rready
    if (ar_take) begin
      st_next.arready = 1'b0;
      st_next.rvalid = 1'b1;
      st_next.rresp = rtccal_pkg::RESP_OKAY;
      st_next.rdata = 32'h00000000;
      unique case (ar_word)
        rtccal_pkg::OFF_DAY: begin
          st_next.rdata[5:0] = st_reg.day;
        end
        rtccal_pkg::OFF_MONTH: begin
          if (st_reg.page) st_next.rdata[rtccal_pkg::FMT_BIT] = st_reg.fmt;
          else st_next.rdata[4:0] = st_reg.month;
        end
        rtccal_pkg::OFF_YEAR: begin
          if (st_reg.page) st_next.rdata[1:0] = st_reg.leap;
          else st_next.rdata[7:0] = st_reg.year;
        end
        rtccal_pkg::OFF_PAGE: begin
          st_next.rdata[rtccal_pkg::PAGE_BIT] = st_reg.page;
        end
        default: begin
          st_next.rresp = rtccal_pkg::RESP_SLVERR;
        end
      endcase
    end else if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
      st_next.arready = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= rtccal_pkg::ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready = st_reg.wready;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rresp = st_reg.rresp;
  assign s_axi_rdata = st_reg.rdata;
  assign hour_format_24 = st_reg.fmt;
  assign page_one = st_reg.page;

  logic day_rd;
  logic month_rd;
  logic year_rd;
  logic is_dec31;
  assign day_rd = ar_take && (ar_word == rtccal_pkg::OFF_DAY);
  assign month_rd = ar_take && (ar_word == rtccal_pkg::OFF_MONTH);
  assign year_rd = ar_take && (ar_word == rtccal_pkg::OFF_YEAR);
  assign is_dec31 = ({2'h0, st_reg.day} == rtccal_pkg::DAY_31) && ({3'h0, st_reg.month} == rtccal_pkg::MON_DEC);

  a_day_read_p0: assert property (@(posedge aclk) disable iff (!aresetn)
    day_rd && !st_reg.page |=> s_axi_rvalid && s_axi_rdata == {26'h0, $past(st_reg.day)})
    else $error("day read on page zero wrong");

  a_day_read_p1: assert property (@(posedge aclk) disable iff (!aresetn)
    day_rd && st_reg.page |=> s_axi_rvalid && s_axi_rdata == {26'h0, $past(st_reg.day)})
    else $error("day read on page one wrong");

  a_month_read: assert property (@(posedge aclk) disable iff (!aresetn)
    month_rd && !st_reg.page |=> s_axi_rdata[31:5] == 27'h0 && s_axi_rdata[4:0] == $past(st_reg.month))
    else $error("month read wrong");

  a_month_page: assert property (@(posedge aclk) disable iff (!aresetn)
    month_rd && st_reg.page && st_reg.fmt != st_reg.month[0] |=> s_axi_rdata[0] != $past(st_reg.month[0]))
    else $error("page one month location shows month");

  a_format_read: assert property (@(posedge aclk) disable iff (!aresetn)
    month_rd && st_reg.page |=> s_axi_rdata == {31'h0, $past(st_reg.fmt)})
    else $error("format bit read wrong");

  a_year_read: assert property (@(posedge aclk) disable iff (!aresetn)
    year_rd && !st_reg.page |=> s_axi_rdata == {24'h0, $past(st_reg.year)})
    else $error("year read wrong");

  a_leap_read: assert property (@(posedge aclk) disable iff (!aresetn)
    year_rd && st_reg.page |=> s_axi_rdata == {30'h0, $past(st_reg.leap)})
    else $error("leap phase read wrong");

  a_leap_step: assert property (@(posedge aclk) disable iff (!aresetn)
    day_carry && is_dec31 && !wr_go |=> st_reg.leap == 2'($past(st_reg.leap) + 2'h1)
      && {2'h0, st_reg.day} == rtccal_pkg::BCD_ONE && st_reg.year == $past(cal_step[2]))
    else $error("new year did not step leap phase");

  a_feb_leap: assert property (@(posedge aclk) disable iff (!aresetn)
    day_carry && !wr_go && {3'h0, st_reg.month} == rtccal_pkg::MON_FEB && st_reg.leap == rtccal_pkg::LEAP_YEAR
      && {2'h0, st_reg.day} == rtccal_pkg::DAY_28 |=> {2'h0, st_reg.day} == rtccal_pkg::DAY_29)
    else $error("leap february ended on the 28th");

  a_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_take |=> s_axi_rdata[31:8] == 24'h0)
    else $error("reserved read bits not zero");

  a_day_write_p1: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && wr_lane0 && aw_word == rtccal_pkg::OFF_DAY && st_reg.page |=> st_reg.day == $past(wbyte[5:0]))
    else $error("day write on page one lost");

  a_day_code: assert property (@(posedge aclk) disable iff (!aresetn)
    day_carry && !wr_go |=> {2'h0, st_reg.day} >= rtccal_pkg::BCD_ONE && {2'h0, st_reg.day} <= rtccal_pkg::DAY_31
      && st_reg.day[3:0] <= 4'h9)
    else $error("day stepped to an invalid code");

  a_day_zero_hi: assert property (@(posedge aclk) disable iff (!aresetn)
    day_rd |=> s_axi_rdata[31:6] == 26'h0)
    else $error("day read upper bits not zero");

  a_month_code: assert property (@(posedge aclk) disable iff (!aresetn)
    day_carry && !wr_go |=> {3'h0, st_reg.month} >= rtccal_pkg::BCD_ONE
      && {3'h0, st_reg.month} <= rtccal_pkg::MON_DEC && st_reg.month[3:0] <= 4'h9)
    else $error("month stepped to an invalid code");

  a_new_year_month: assert property (@(posedge aclk) disable iff (!aresetn)
    day_carry && !wr_go && is_dec31 |=> {3'h0, st_reg.month} == rtccal_pkg::BCD_ONE)
    else $error("month did not wrap to january");

  a_year_code: assert property (@(posedge aclk) disable iff (!aresetn)
    day_carry && !wr_go |=> st_reg.year[7:4] <= 4'h9 && st_reg.year[3:0] <= 4'h9)
    else $error("year stepped to an invalid code");

  a_fmt_write_p1: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && wr_lane0 && aw_word == rtccal_pkg::OFF_MONTH && st_reg.page && !day_carry
      |=> $stable(st_reg.month) && st_reg.fmt == $past(wbyte[rtccal_pkg::FMT_BIT]))
    else $error("page one month write hit the month");

  a_month_write_p0: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && wr_lane0 && aw_word == rtccal_pkg::OFF_MONTH && !st_reg.page
      |=> $stable(st_reg.fmt) && st_reg.month == $past(wbyte[4:0]))
    else $error("page zero month write hit the format bit");

  a_fmt_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !(wr_go && aw_word == rtccal_pkg::OFF_MONTH && st_reg.page) |=> $stable(hour_format_24))
    else $error("hour format changed without a write");

  a_year_write_p0: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && wr_lane0 && aw_word == rtccal_pkg::OFF_YEAR && !st_reg.page && !day_carry
      |=> st_reg.year == $past(wbyte) && $stable(st_reg.leap))
    else $error("page zero year write wrong");

  a_year_write_p1: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && wr_lane0 && aw_word == rtccal_pkg::OFF_YEAR && st_reg.page && !day_carry
      |=> $stable(st_reg.year) && st_reg.leap == $past(wbyte[1:0]))
    else $error("page one year write hit the year");

  a_year_zero_hi: assert property (@(posedge aclk) disable iff (!aresetn)
    year_rd && st_reg.page |=> s_axi_rdata[31:2] == 30'h0)
    else $error("leap read upper bits not zero");

  a_leap_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !(day_carry && is_dec31) && !(wr_go && aw_word == rtccal_pkg::OFF_YEAR && st_reg.page)
      |=> $stable(st_reg.leap))
    else $error("leap phase moved outside a new year");

  a_month_zero_hi: assert property (@(posedge aclk) disable iff (!aresetn)
    month_rd |=> s_axi_rdata[31:5] == 27'h0)
    else $error("month location upper bits not zero");

endmodule : rtccal_top

// ==== rtccal_top_bench.sv ====
/*
 * Self-checking bench for the calendar date registers: AXI4-Lite reads and
 * writes, page switching, reserved bits, unmapped offsets, day carry rollover.
 * Assumes the register map and timing of the design's package and notes.
 */
`timescale 1ns/1ps
module rtccal_top_bench;
  localparam logic [1:0] OK = rtccal_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = rtccal_pkg::RESP_SLVERR;
  localparam logic [11:0] A_DAY = rtccal_pkg::OFF_DAY;
  localparam logic [11:0] A_MON = rtccal_pkg::OFF_MONTH;
  localparam logic [11:0] A_YR = rtccal_pkg::OFF_YEAR;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [2:0] s_axi_awprot = 3'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [2:0] s_axi_arprot = 3'h0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic day_carry = 1'b0;
  logic hour_format_24;
  logic page_one;
  int seed = 32'hc30b;
  int bad_count = 0;
  int cmp_count = 0;
  int m, y, l, ld;
  logic [31:0] r;

  always #12.5 aclk = ~aclk;

  rtccal_top rtccal_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(s_axi_awprot), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .day_carry(day_carry), .hour_format_24(hour_format_24), .page_one(page_one));

  function automatic logic [7:0] bcd(input int n);
    return 8'((n / 10) * 16 + n % 10);
  endfunction : bcd

  function automatic int last_day(input int mo, input int lp);
    if (mo == 2) return (lp == 0) ? 29 : 28;
    if (mo == 4 || mo == 6 || mo == 9 || mo == 11) return 30;
    return 31;
  endfunction : last_day

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awprot <= 3'($random(seed));
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done && n < 100) begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        done = 1'b1;
        s_axi_bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
      end
    end
    if (!done) chk("write answer", 32'h1, 32'h0);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arprot <= 3'($random(seed));
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done && n < 100) begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        done = 1'b1;
        s_axi_rready <= 1'b0;
        chk("rdata", e, s_axi_rdata);
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
      end
    end
    if (!done) chk("read answer", 32'h1, 32'h0);
  endtask : rd

  task automatic pg(input logic p);
    wr(rtccal_pkg::OFF_PAGE, {$random(seed)} & 32'hFFFFFFFE | {31'h0, p}, 4'hF, OK);
  endtask : pg

  task automatic carry();
    @(posedge aclk);
    day_carry <= 1'b1;
    @(posedge aclk);
    day_carry <= 1'b0;
  endtask : carry

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test

  initial begin
    #(25 * 20000);
    bad_count++;
    end_of_test();
  end

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    chk("page_one", 32'h0, {31'h0, page_one});
    // Random fields with reserved bits set
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      pg(r[0]);
      wr(A_DAY, {r[31:8], 2'b11, 6'(bcd(1 + i * 4))}, 4'hF, OK);
      pg(~r[0]);
      rd(A_DAY, {26'h0, 6'(bcd(1 + i * 4))}, OK);
      pg(1'b0);
      m = 1 + {$random(seed)} % 12;
      y = {$random(seed)} % 100;
      wr(A_MON, {r[31:8], 3'b111, 5'(bcd(m))}, 4'hF, OK);
      rd(A_MON, {27'h0, 5'(bcd(m))}, OK);
      wr(A_YR, {r[31:8], bcd(y)}, 4'hF, OK);
      rd(A_YR, {24'h0, bcd(y)}, OK);
    end
    wr(A_DAY, 32'h00000001, 4'hF, OK);
    // Page one shows format and leap phase
    pg(1'b1);
    chk("page_one", 32'h1, {31'h0, page_one});
    for (int f = 0; f < 2; f++) begin
      wr(A_MON, {$random(seed)} & 32'hFFFFFFFE | f, 4'hF, OK);
      rd(A_MON, f, OK);
      chk("hour_format_24", f, {31'h0, hour_format_24});
    end
    for (l = 0; l < 4; l++) begin
      wr(A_YR, {$random(seed)} & 32'hFFFFFFFC | l, 4'hF, OK);
      rd(A_YR, l, OK);
    end
    pg(1'b0);
    rd(A_MON, {27'h0, 5'(bcd(m))}, OK);
    rd(A_YR, {24'h0, bcd(y)}, OK);
    wr(A_DAY, 32'h00000015, 4'h0, OK);
    rd(A_DAY, 32'h00000001, OK);
    wr(12'h010, 32'h000000FF, 4'hF, ERR);
    rd(12'h010, 32'h0, ERR);
    rd(12'hFFC, 32'h0, ERR);
    for (m = 1; m <= 12; m++) begin
      l = {$random(seed)} % 4;
      y = {$random(seed)} % 100;
      ld = last_day(m, l);
      pg(1'b1);
      wr(A_YR, l, 4'hF, OK);
      pg(1'b0);
      wr(A_MON, bcd(m), 4'hF, OK);
      wr(A_YR, bcd(y), 4'hF, OK);
      wr(A_DAY, bcd(ld - 1), 4'hF, OK);
      carry();
      rd(A_DAY, bcd(ld), OK);
      carry();
      rd(A_DAY, 32'h1, OK);
      rd(A_MON, (m == 12) ? 32'h1 : bcd(m + 1), OK);
      rd(A_YR, (m == 12) ? bcd((y + 1) % 100) : bcd(y), OK);
      pg(1'b1);
      rd(A_YR, (m == 12) ? (l + 1) % 4 : l, OK);
    end
    end_of_test();
  end
endmodule : rtccal_top_bench
